//--- bench/flash_write_status_reporting_test.sv
// self-checking bench of the flash status poller against a behavioural device
`timescale 1ns/100ps
module flash_write_status_reporting_test;
  import fws_pkg::*;
  localparam logic [23:0] PA     = 24'h012340;
  localparam logic [15:0] ARR    = 16'hC35B;  // bit6 high, equal to the last toggle value
  localparam logic [23:0] ABA[3] = '{ADR_UNLK1, ADR_UNLK2, ADR_UNLK1};
  localparam logic [7:0]  ABD[3] = '{CMD_UNLK1, CMD_UNLK2, CMD_RST};
  logic        clk     = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [23:0] flash_addr;
  logic        flash_ce_n;
  logic        flash_oe_n;
  logic        flash_we_n;
  logic [15:0] flash_dq_o;
  logic        flash_dq_oe;
  logic [15:0] dq_out;
  logic        rb_low;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors = 0;
  int          checks     = 0;

  // ------------------------------------------------------------
  // clock, design and device
  // ------------------------------------------------------------
  always #4 clk = ~clk;

  fws_poller dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_oe ? flash_dq_o : dq_out), .flash_ready_busy_n(!rb_low)
  );

  fws_flash_model flash (
    .addr(flash_addr), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .dq_in(flash_dq_o),
    .dq_out(dq_out), .rb_low(rb_low)
  );

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic summarize();
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  // one apb transfer, held until pready is seen high; one idle edge follows it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask

  // load the device, start a run, optionally stop it, wait until idle
  task automatic run(input int n, input logic to, input logic ab, input logic su,
                     input logic [31:0] ctl, input logic stp);
    int k;
    flash.left = n;
    flash.tout = to;
    flash.abt  = ab;
    flash.susp = su;
    flash.t1   = 1'b0;
    flash.nother = 0;
    flash.wq.delete();
    apb(1'b1, OFS_CTRL, ctl);
    if (stp)
    begin
      repeat (5) apb(1'b0, OFS_STAT, 32'h0);
      chk("stat_busy", 32'h1, {31'h0, rdat[STAT_BUSY]});
      chk("stat_rb_busy", 32'h0, {31'h0, rdat[STAT_RB]});
      apb(1'b1, OFS_CTRL, 32'h2);
    end
    k = 0;
    do
    begin
      apb(1'b0, OFS_STAT, 32'h0);
      k++;
    end
    while (rdat[STAT_BUSY] !== 1'b0 && k < 2000);
    chk("run_idle", 32'h0, {31'h0, rdat[STAT_BUSY]});
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(OFS_STAT, 32'hFF, 32'h40, "stat_reset");
    rd(OFS_CNT, 32'hFFFFFFFF, 32'h0, "cnt_reset");
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdat);
    apb(1'b1, OFS_ADDR, {8'h00, PA});
    rd(OFS_ADDR, 32'hFFFFFF, {8'h00, PA}, "addr_reg");
    flash.pa  = PA;
    flash.arr = ARR;
    // finished at once: two equal reads, then array data
    run(0, 1'b0, 1'b0, 1'b0, 32'h1, 1'b0);
    rd(OFS_STAT, 32'h7F, 32'h42, "stat_quick");
    rd(OFS_DATA, 32'hFFFF, {16'h0, ARR}, "data_quick");
    chk("other_reads", 32'h0, flash.nother);
    // four toggling reads, then completion
    run(4, 1'b0, 1'b0, 1'b0, 32'h1, 1'b0);
    rd(OFS_STAT, 32'h3F, 32'h02, "stat_toggle");
    rd(OFS_CNT, 32'hFFFFFFFF, 32'h5, "cnt_toggle");
    rd(OFS_DATA, 32'hFFFF, {16'h0, ARR}, "data_toggle");
    // toggle stops just as the timeout flag rises
    run(2, 1'b1, 1'b0, 1'b0, 32'h1, 1'b0);
    rd(OFS_STAT, 32'h3F, 32'h22, "stat_late");
    rd(OFS_DATA, 32'hFFFF, {16'h0, ARR}, "data_late");
    // timeout with toggling kept up: failure and one reset write
    run(-1, 1'b1, 1'b0, 1'b0, 32'h1, 1'b0);
    rd(OFS_STAT, 32'h3C, 32'h24, "stat_fail");
    chk("rst_count", 32'h1, flash.wq.size());
    chk("rst_write", {PA, CMD_RST}, {flash.wq[0][39:16], flash.wq[0][7:0]});
    chk("array_back", 32'h0, flash.left);
    // aborted buffer write: three-write reset sequence
    run(-1, 1'b1, 1'b1, 1'b0, 32'h1, 1'b0);
    rd(OFS_STAT, 32'h3C, 32'h2C, "stat_abort");
    chk("abort_count", 32'h3, flash.wq.size());
    for (int i = 0; i < 3; i++)
      chk("abort_seq", {ABA[i], ABD[i]}, {flash.wq[i][39:16], flash.wq[i][7:0]});
    // erase suspended: second toggle flag moves, first stands
    run(0, 1'b0, 1'b0, 1'b1, 32'h5, 1'b0);
    rd(OFS_STAT, 32'hDD, 32'hD0, "stat_susp");
    rd(OFS_CTRL, 32'h7, 32'h4, "ctrl_t2");
    flash.susp = 1'b0;
    // host leaves polling: stop ends the run without a verdict
    run(-1, 1'b0, 1'b0, 1'b0, 32'h1, 1'b1);
    rd(OFS_STAT, 32'h07, 32'h00, "stat_stop");
    flash.left = 0;
    summarize();
  end

  // hang guard, far beyond the few hundred cycles the runs take
  initial
  begin
    #(8 * 60000);
    num_errors++;
    summarize();
  end
endmodule

//--- bench/fws_flash_model.sv
// behavioural flash device answering the poller's status reads and reset writes
`timescale 1ns/100ps
module fws_flash_model (
  // flash pins from the controller
  input  wire logic [23:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] dq_in,
  // device answers
  output logic [15:0]      dq_out,
  output logic             rb_low
);
  import fws_pkg::*;
  // ------------------------------------------------------------
  // operation state, loaded by the bench before each run
  // ------------------------------------------------------------
  int          left   = 0;      // toggling reads still to come, -1 never ends
  logic        tout   = 1'b0;   // only a real limit overrun, never a masked bit
  logic        abt    = 1'b0;
  logic        susp   = 1'b0;
  logic [23:0] pa     = 24'h000000;
  logic [15:0] arr    = 16'h0000;
  logic        t1     = 1'b0;
  logic        t2     = 1'b0;
  logic [15:0] held   = 16'h0000;
  int          nother = 0;
  logic [39:0] wq[$];
  logic [15:0] cur;

  // status word while an operation or suspend is pending, array word otherwise
  always_comb
  begin
    if (left != 0 || susp)
      cur = {8'h00, ~arr[7], t1, tout, 1'b0, susp, t2, abt, 1'b0};
    else
      cur = arr;
  end

  // a released or deselected bus shows the inverse of the last word, never a stale copy
  assign dq_out = (!oe_n && !ce_n) ? cur : ~held;
  assign rb_low = (left != 0) && !susp;

  // status bits advance only when output enable is released
  always @(posedge oe_n)
  begin
    held = cur;
    if (addr != pa)
      nother++;
    if (susp)
      t2 = ~t2;
    else if (left != 0)
    begin
      t1 = ~t1;
      if (left > 0)
        left--;
    end
  end

  // reset command returns to array read; after an abort only the full sequence does
  always @(posedge we_n)
  begin
    wq.push_back({addr, dq_in});
    if (dq_in[7:0] == CMD_RST && (!abt || (wq.size() >= 3
        && wq[wq.size()-2][7:0] == CMD_UNLK2 && wq[wq.size()-3][7:0] == CMD_UNLK1)))
    begin
      left = 0;
      tout = 1'b0;
      abt  = 1'b0;
    end
  end
endmodule

//--- hw/fws_bus_if.sv
// request and answer link between poll sequencer and flash cycle engine
`timescale 1ns/100ps
interface fws_bus_if #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 24
);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport ctl (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

//--- hw/fws_cycle_engine.sv
// one asynchronous flash read or write cycle with strobe release after it
`timescale 1ns/100ps
module fws_cycle_engine #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 24
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // sequencer side
  fws_bus_if.eng                 bus,
  // flash pins
  output logic [ADDR_W-1:0]      addr_reg,
  output logic                   ce_n_reg,
  output logic                   oe_n_reg,
  output logic                   we_n_reg,
  output logic [DATA_W-1:0]      dq_o_reg,
  output logic                   dq_oe_reg,
  input  wire logic [DATA_W-1:0] dq_i
);
  import fws_pkg::*;

  fws_eng_t         st_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic             done_reg;

  assign bus.done  = done_reg;
  assign bus.rdata = rdata_reg;

  // cycle sequencing and counter
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_reg   <= EN_IDLE;
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (st_reg)
        EN_IDLE:
        begin
          cnt_reg <= '0;
          if (bus.req)
            st_reg <= EN_ACT;
        end
        EN_ACT:
        begin
          if (cnt_reg == CNT_W'(ACC_CYC - 1))
          begin
            cnt_reg <= '0;
            st_reg  <= EN_GAP;
          end
          else
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
        EN_GAP:
        begin
          if (cnt_reg == CNT_W'(GAP_CYC - 1))
          begin
            done_reg <= 1'b1; // strobes already released
            st_reg   <= EN_IDLE;
          end
          else
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
      endcase
    end
  end

  // pins and read capture; every cycle ends with ce and oe high
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      addr_reg  <= '0;
      ce_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      we_n_reg  <= 1'b1;
      dq_o_reg  <= '0;
      dq_oe_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else if (st_reg == EN_IDLE && bus.req)
    begin
      addr_reg  <= bus.addr;
      dq_o_reg  <= bus.wdata;
      dq_oe_reg <= bus.wr;
      ce_n_reg  <= 1'b0;
      oe_n_reg  <= bus.wr;
      we_n_reg  <= !bus.wr;
    end
    else if (st_reg == EN_ACT && cnt_reg == CNT_W'(ACC_CYC - 1))
    begin
      if (!oe_n_reg)
        rdata_reg <= dq_i;
      ce_n_reg <= 1'b1; // data latched on this rising strobe edge
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
    end
    else if (st_reg == EN_GAP && cnt_reg == CNT_W'(GAP_CYC - 1))
      dq_oe_reg <= 1'b0;
  end

  // assertions
  strobe_release_a: assert property (@(posedge clk) disable iff (!resetn)
    done_reg |-> ce_n_reg && oe_n_reg && we_n_reg)
    else $error("strobes not released at end of cycle");
endmodule

//--- hw/fws_pkg.sv
// constants, types and register map of the flash status poller
package fws_pkg;
  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam int        APB_AW   = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_CNT  = 8'h10;
  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_USE_T2 = 2;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_FAIL   = 2;
  localparam int STAT_ABORT  = 3;
  localparam int STAT_SUSP   = 4;
  localparam int STAT_TOUT   = 5;
  localparam int STAT_RB     = 6;
  localparam int STAT_ESTART = 7;
  // ---------------------------------------------------------------
  // status bit positions on the flash data lines
  // ---------------------------------------------------------------
  localparam int BIT_DPOLL  = 7;
  localparam int BIT_T1     = 6;
  localparam int BIT_TOUT   = 5;
  localparam int BIT_ESTART = 3;
  localparam int BIT_T2     = 2;
  localparam int BIT_ABORT  = 1;
  // ---------------------------------------------------------------
  // command words and addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_RST    = 8'hF0;
  localparam logic [7:0]  CMD_UNLK1  = 8'hAA;
  localparam logic [7:0]  CMD_UNLK2  = 8'h55;
  localparam logic [23:0] ADR_UNLK1  = 24'h000555;
  localparam logic [23:0] ADR_UNLK2  = 24'h0002AA;
  localparam logic [1:0]  LAST_RST   = 2'h0;
  localparam logic [1:0]  LAST_ABORT = 2'h2;
  // ---------------------------------------------------------------
  // bus timing
  // ---------------------------------------------------------------
  localparam int CLK_NS   = 8;
  localparam int T_ACC_NS = 100;
  localparam int T_GAP_NS = 24;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC  = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W    = 8;
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RD1, ST_RD2, ST_RD3, ST_ARRAY, ST_CMD} fws_state_t;
  typedef enum logic [1:0] {EN_IDLE, EN_ACT, EN_GAP} fws_eng_t;
endpackage

//--- hw/fws_poller.sv
// flash write status poller: apb registers and toggle bit polling sequence
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/100ps
module fws_poller #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 24
)(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [fws_pkg::APB_AW-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  // flash pins
  output logic [ADDR_W-1:0]                 flash_addr,
  output logic                              flash_ce_n,
  output logic                              flash_oe_n,
  output logic                              flash_we_n,
  output logic [DATA_W-1:0]                 flash_dq_o,
  output logic                              flash_dq_oe,
  input  wire logic [DATA_W-1:0]            flash_dq_i,
  input  wire logic                         flash_ready_busy_n
);
  import fws_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (DATA_W < 8 || DATA_W > 32 || ADDR_W < 12 || ADDR_W > 32)
  begin : g_bad_width
    $error("fws_poller: unsupported data or address width");
  end

  fws_bus_if #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) bus ();

  fws_cycle_engine #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_eng (
    .clk       (clk),
    .resetn    (resetn),
    .bus       (bus),
    .addr_reg  (flash_addr),
    .ce_n_reg  (flash_ce_n),
    .oe_n_reg  (flash_oe_n),
    .we_n_reg  (flash_we_n),
    .dq_o_reg  (flash_dq_o),
    .dq_oe_reg (flash_dq_oe),
    .dq_i      (flash_dq_i)
  );

  fws_state_t        state_reg;
  logic              pend_reg, req_reg, wr_reg, stop_reg, use_t2_reg, rb_reg;
  logic [ADDR_W-1:0] poll_addr_reg, baddr_reg;
  logic [DATA_W-1:0] wdata_reg, prev_reg, data_reg;
  logic              done_f, fail_f, abort_f, susp_f, tout_f, estart_f;
  logic [15:0]       cnt_reg;
  logic [1:0]        cmd_idx_reg, cmd_last_reg;
  logic              pready_reg, pslverr_reg;
  logic [31:0]       prdata_reg, rd_mux;
  logic              setup, apb_wr, start_w, stop_w, t1, t2, tout, abort, susp_cond;

  assign bus.req   = req_reg;
  assign bus.wr    = wr_reg;
  assign bus.addr  = baddr_reg;
  assign bus.wdata = wdata_reg;
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // transfer strobes; answer comes in the first access cycle
  assign setup   = psel && !penable;
  assign apb_wr  = psel && penable && pwrite && pready_reg;
  assign start_w = apb_wr && paddr == OFS_CTRL && pwdata[CTRL_START] && state_reg == ST_IDLE;
  assign stop_w  = apb_wr && paddr == OFS_CTRL && pwdata[CTRL_STOP];

  // read data selection
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      OFS_CTRL: rd_mux[CTRL_USE_T2] = use_t2_reg;
      OFS_ADDR: rd_mux[ADDR_W-1:0] = poll_addr_reg;
      OFS_STAT:
      begin
        rd_mux[STAT_BUSY]   = state_reg != ST_IDLE;
        rd_mux[STAT_DONE]   = done_f;
        rd_mux[STAT_FAIL]   = fail_f;
        rd_mux[STAT_ABORT]  = abort_f;
        rd_mux[STAT_SUSP]   = susp_f;
        rd_mux[STAT_TOUT]   = tout_f;
        rd_mux[STAT_RB]     = rb_reg;
        rd_mux[STAT_ESTART] = estart_f;
      end
      OFS_DATA: rd_mux[DATA_W-1:0] = data_reg;
      OFS_CNT:  rd_mux[15:0] = cnt_reg;
      default:  rd_mux = 32'h00000000;
    endcase
  end

  // answer phase and unmapped decode
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !(paddr inside {OFS_CTRL, OFS_ADDR, OFS_STAT, OFS_DATA, OFS_CNT});
      prdata_reg  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // configuration registers; ready_busy_n sampled as a plain level
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      poll_addr_reg <= '0;
      use_t2_reg    <= 1'b0;
      rb_reg        <= 1'b1;
    end
    else
    begin
      rb_reg <= flash_ready_busy_n; // valid after final write strobe
      if (apb_wr && paddr == OFS_ADDR)
        poll_addr_reg <= pwdata[ADDR_W-1:0]; // last loaded buffer address for buffer writes
      if (apb_wr && paddr == OFS_CTRL)
        use_t2_reg <= pwdata[CTRL_USE_T2];
    end
  end

  // ---------------------------------------------------------------
  // polling sequence
  // ---------------------------------------------------------------
  // toggle detection against the previous status read
  assign t1        = bus.rdata[BIT_T1] ^ prev_reg[BIT_T1];
  assign t2        = bus.rdata[BIT_T2] ^ prev_reg[BIT_T2];
  assign tout      = bus.rdata[BIT_TOUT];
  assign abort     = bus.rdata[BIT_ABORT];
  assign susp_cond = use_t2_reg && t2 && !t1;

  // sequencer and sticky result flags, cleared by each new start
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      {done_f, fail_f, abort_f, susp_f, tout_f, estart_f, stop_reg} <= '0;
      prev_reg <= '0;
      data_reg <= '0;
      cnt_reg  <= 16'h0000;
      cmd_idx_reg  <= 2'h0;
      cmd_last_reg <= LAST_RST;
    end
    else if (start_w)
    begin
      state_reg <= ST_RD1; // always from the first step
      {done_f, fail_f, abort_f, susp_f, tout_f, estart_f, stop_reg} <= '0;
      cnt_reg <= 16'h0000;
    end
    else
    begin
      if (stop_w && state_reg != ST_CMD)
        stop_reg <= 1'b1;
      if (bus.done && state_reg != ST_CMD && state_reg != ST_ARRAY)
      begin
        cnt_reg  <= cnt_reg + 16'h0001;
        prev_reg <= bus.rdata;
        tout_f   <= tout_f | tout;
        estart_f <= estart_f | bus.rdata[BIT_ESTART];
      end
      if (bus.done)
        unique case (state_reg)
          ST_RD1: state_reg <= stop_reg ? ST_IDLE : ST_RD2; // second consecutive read
          ST_RD2:
          begin
            if (susp_cond)
            begin
              susp_f    <= 1'b1; // sector selected, erase suspended
              state_reg <= ST_IDLE;
            end
            else if (!t1 && !(use_t2_reg && t2))
              state_reg <= ST_ARRAY; // stopped toggling: done
            else if (tout)
              state_reg <= ST_RD3; // recheck after timeout flag
            else if (stop_reg)
              state_reg <= ST_IDLE;
          end
          ST_RD3:
          begin
            if (!t1)
              state_reg <= ST_ARRAY; // stopped just as timeout rose
            else
            begin
              fail_f       <= 1'b1;
              abort_f      <= abort;
              cmd_idx_reg  <= 2'h0;
              cmd_last_reg <= abort ? LAST_ABORT : LAST_RST;
              state_reg    <= ST_CMD; // reset after failure
            end
          end
          ST_ARRAY:
          begin
            data_reg  <= bus.rdata; // array data on the following read
            done_f    <= 1'b1;
            state_reg <= ST_IDLE;
          end
          ST_CMD:
          begin
            cmd_idx_reg <= cmd_idx_reg + 2'h1;
            if (cmd_idx_reg == cmd_last_reg)
              state_reg <= ST_IDLE;
          end
          ST_IDLE: state_reg <= ST_IDLE;
        endcase
    end
  end

  // cycle requests; status reads always at the poll address
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      {req_reg, pend_reg, wr_reg} <= '0;
      baddr_reg <= '0;
      wdata_reg <= '0;
    end
    else if (req_reg)
      req_reg <= 1'b0;
    else if (bus.done)
      pend_reg <= 1'b0;
    else if (state_reg != ST_IDLE && !pend_reg)
    begin
      req_reg   <= 1'b1;
      pend_reg  <= 1'b1;
      wr_reg    <= state_reg == ST_CMD;
      baddr_reg <= poll_addr_reg;
      wdata_reg <= DATA_W'(CMD_RST);
      if (state_reg == ST_CMD && cmd_last_reg == LAST_ABORT)
        unique case (cmd_idx_reg)
          2'h0:
          begin
            baddr_reg <= ADDR_W'(ADR_UNLK1); // abort reset sequence
            wdata_reg <= DATA_W'(CMD_UNLK1);
          end
          2'h1:
          begin
            baddr_reg <= ADDR_W'(ADR_UNLK2);
            wdata_reg <= DATA_W'(CMD_UNLK2);
          end
          default: baddr_reg <= ADDR_W'(ADR_UNLK1);
        endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  restart_first_a: assert property (start_w |=> state_reg == ST_RD1 && cnt_reg == 16'h0000)
    else $error("start did not restart at first read");
  same_address_a: assert property (req_reg && !wr_reg |-> baddr_reg == poll_addr_reg)
    else $error("status read away from poll address");
  two_reads_a: assert property ($rose(done_f) |-> $past(cnt_reg) >= 16'h0002)
    else $error("done reported after fewer than two reads");
  array_data_a: assert property (state_reg == ST_ARRAY && bus.done |=> done_f && state_reg == ST_IDLE)
    else $error("array read not finished");
  recheck_tout_a: assert property (state_reg == ST_RD2 && bus.done && t1 && tout && !susp_cond |=> state_reg == ST_RD3)
    else $error("no recheck after timeout flag");
  fail_reset_a: assert property (state_reg == ST_RD3 && bus.done && t1 |=> state_reg == ST_CMD ##[1:3] req_reg && wr_reg)
    else $error("failure not followed by reset write");
  abort_seq_a: assert property (state_reg == ST_RD3 && bus.done && t1 && abort |=> cmd_last_reg == LAST_ABORT && abort_f)
    else $error("abort not answered by abort reset sequence");
  suspend_combine_a: assert property ($rose(susp_f) |-> $past(susp_cond))
    else $error("suspend reported without combined toggle evidence");
  status_addr_a: assert property (state_reg == ST_RD2 && req_reg |-> !wr_reg && baddr_reg == poll_addr_reg)
    else $error("address-bound status read at wrong address");

  poll_ok_c: cover property (state_reg == ST_ARRAY && bus.done);
  poll_fail_c: cover property (state_reg == ST_CMD && cmd_last_reg == LAST_ABORT && bus.done);
  poll_susp_c: cover property ($rose(susp_f));
endmodule
